// ### rif_pkg.sv
// Package: constants and state carriers for the receiver interrupt and fault-flag block
package rif_pkg;

   // Serial control framing
   localparam logic [7:0] RIF_CHIP_ADDR      = 8'he8;  // Chip address byte for these registers
   localparam logic [3:0] RIF_CMD_INT_EN     = 4'h8;   // Interrupt source enables
   localparam logic [3:0] RIF_CMD_ERR_CFG    = 4'h9;   // Fault pin configuration
   localparam int         RIF_ADDR_BITS      = 8;      // Bits in the chip address phase
   localparam int         RIF_DATA_BITS      = 16;     // Bits in the data phase
   localparam int         RIF_POS_CAL        = 0;      // Low chip address bit in data word
   localparam int         RIF_POS_ADDR_HI    = 1;      // High chip address bit in data word
   localparam int         RIF_POS_CMD        = 4;      // Command address field low bit
   localparam int         RIF_POS_BYTE       = 8;      // Register data byte low bit

   // Interrupt enable bit positions
   localparam int RIF_IE_FAULT   = 0;                  // Fault pin change
   localparam int RIF_IE_DETECT  = 1;                  // Input detect change
   localparam int RIF_IE_FS      = 2;                  // fs calculation update
   localparam int RIF_IE_CHSTAT  = 3;                  // Channel status update
   localparam int RIF_IE_NONPCM  = 4;                  // Non-PCM indicator change
   localparam int RIF_IE_PC      = 5;                  // Burst Pc update
   localparam int RIF_IE_SLIP    = 6;                  // Slip in slave mode
   localparam int RIF_IE_EMPH    = 7;                  // Emphasis flag

   // Fault configuration bit positions
   localparam int RIF_EC_CONTENT = 0;                  // Fault content select
   localparam int RIF_EC_PARITY  = 1;                  // Parity flag mode
   localparam int RIF_EC_WAIT    = 2;                  // Clock switch wait, 2 bits
   localparam int RIF_EC_FORCE   = 4;                  // Force fault high
   localparam int RIF_EC_FS_UPDATE_ENABLE   = 5;                  // fs change kept out of fault
   localparam int RIF_EC_RELEASE = 6;                  // Fault release delay, 2 bits

   // Reset values
   localparam logic [7:0] RIF_INT_EN_RST  = 8'h00;
   localparam logic [7:0] RIF_ERR_CFG_RST = 8'h00;

   // Clock switch wait times and their cycle counts
   localparam int RIF_CLK_MHZ     = 10;                // System clock rate
   localparam int RIF_WAIT0_US    = 200;
   localparam int RIF_WAIT1_US    = 100;
   localparam int RIF_WAIT2_US    = 50;
   localparam int RIF_WAIT3_US    = 400;
   localparam logic [11:0] RIF_WAIT0_CYC = 12'(RIF_WAIT0_US * RIF_CLK_MHZ);
   localparam logic [11:0] RIF_WAIT1_CYC = 12'(RIF_WAIT1_US * RIF_CLK_MHZ);
   localparam logic [11:0] RIF_WAIT2_CYC = 12'(RIF_WAIT2_US * RIF_CLK_MHZ);
   localparam logic [11:0] RIF_WAIT3_CYC = 12'(RIF_WAIT3_US * RIF_CLK_MHZ);

   // Preamble B counts before fault release
   localparam logic [5:0] RIF_REL0_CNT = 6'd48;
   localparam logic [5:0] RIF_REL1_CNT = 6'd24;
   localparam logic [5:0] RIF_REL2_CNT = 6'd12;
   localparam logic [5:0] RIF_REL3_CNT = 6'd6;

   // Clock switch sequencer
   typedef enum logic [1:0] {RIF_SW_IDLE, RIF_SW_AMP, RIF_SW_COUNT} rif_sw_t;

   // Link-side serial receiver state
   typedef struct packed {
      logic [7:0]  addr_sh;
      logic [3:0]  addr_cnt;
      logic [15:0] data_sh;
      logic [4:0]  data_cnt;
   } rif_link_t;

   // System-side state
   typedef struct packed {
      logic [2:0]  ce_sync;
      logic [1:0]  ahi_sync;
      logic [1:0]  cal_sync;
      logic [7:0]  int_en;
      logic [7:0]  err_cfg;
      logic        det_prev;
      logic        npcm_prev;
      logic        lock_prev;
      logic [47:0] cs_prev;
      logic [15:0] pc_prev;
      logic [5:0]  rel_cnt;
      logic        released;
      rif_sw_t     sw_state;
      logic [11:0] sw_cnt;
      logic        switching;
      logic        clk_osc;
      logic        int_q;
      logic        fault;
      logic        mute;
      logic        parity;
      logic        fs_chg;
      logic        nonpcm;
   } rif_sys_t;

endpackage : rif_pkg

// ### rif_top.sv
// Interrupt pin and receive fault pin logic with its serial register port
//
// Operation
// - Address E8 command 8 holds eight enables
// - Fault pin changes raise interrupt when enabled
// - Input detect changes raise interrupt when enabled
// - fs calculation update raises interrupt when enabled
// - Channel status update raises interrupt when enabled
// - Non-PCM pin changes raise interrupt when enabled
// - Burst Pc update raises interrupt when enabled
// - Slave-mode slips raise interrupt when enabled
// - Emphasis flag drives interrupt when enabled
// - Identical 48 status bits flag an update
// - Matching 16-bit Pc values flag an update
// - Content select adds non-PCM to fault
// - Parity mode chooses non-PCM or subframe output
// - Clock switch waits selected time after amplifier
// - Force bit drives fault pin high
// - Forcing fault leaves audio outputs untouched
// - fs changes fault unless fs bit set
// - With fs bit, only status fs counts
// - Fault releases after selected preamble B count
// - Non-PCM fault mutes audio output
// - Non-PCM follows indicator source select
// - Fault shows during clock source switching while the fs bit is clear and the amplifier is not in continuous operation
`timescale 1ns/1ns

module rif_top
   import rif_pkg::*;
(
   input  wire logic        clk_sys_i,            // System clock
   input  wire logic        rst_n_i,              // Asynchronous reset, active low
   input  wire logic        ctl_clk_i,            // Serial control clock
   input  wire logic        ctl_enable_i,         // Serial control enable, high for data
   input  wire logic        ctl_data_i,           // Serial control data, LSB first
   input  wire logic        chip_addr_high_i,     // Chip address strap, high bit
   input  wire logic        chip_addr_low_i,      // Chip address strap, low bit
   input  wire logic        pll_lock_i,           // PLL locked
   input  wire logic        data_error_i,         // Received data error
   input  wire logic        input_detect_i,       // Input data detected
   input  wire logic        fs_update_i,          // fs calculation result updated
   input  wire logic        calc_fs_change_i,     // fs change from calculation
   input  wire logic        cs_fs_change_i,       // fs change from channel status
   input  wire logic        cs_block_i,           // Channel status block complete
   input  wire logic [47:0] cs_bits_i,            // First 48 channel status bits
   input  wire logic        pc_valid_i,           // Burst Pc received
   input  wire logic [15:0] pc_value_i,           // Burst Pc value
   input  wire logic        nonpcm_a_i,           // Non-PCM definition 0
   input  wire logic        nonpcm_b_i,           // Non-PCM definition 1
   input  wire logic        nonpcm_indicator_source_select_i, // Non-PCM source
   input  wire logic        slip_i,               // Read twice or word lost
   input  wire logic        slave_mode_i,         // Slave clocking mode
   input  wire logic        emphasis_i,           // Emphasis detected
   input  wire logic        parity_burst_i,       // Eight parity errors in a row
   input  wire logic        subframe_err_i,       // Current subframe has error
   input  wire logic        preamble_b_i,         // Preamble B seen
   input  wire logic        osc_amp_start_i,      // Oscillation amplifier started
   input  wire logic        osc_amp_operation_i,  // Amplifier runs continuously
   output logic             int_o,                // Host interrupt pin
   output logic             receive_fault_pin_o,  // Receive fault pin
   output logic             mute_o,               // Audio output mute
   output logic             parity_flag_o,        // Parity error flag
   output logic             fs_change_o,          // fs change seen
   output logic             clk_src_osc_o,        // Clock taken from oscillator
   output logic             nonpcm_o              // Non-PCM indicator pin
);

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: serial shift registers
   ////////////////////////////////////////////////////////////////////////////

   rif_link_t lnk_q;                              // Link state
   rif_link_t lnk_d;                              // Link next state

   // Enable low shifts the chip address, enable high shifts the data word
   always_comb begin
      lnk_d = lnk_q;
      if (!ctl_enable_i) begin
         // Address phase, data count cleared for the next frame
         lnk_d.addr_sh  = {ctl_data_i, lnk_q.addr_sh[7:1]};
         lnk_d.data_cnt = 5'd0;
         if (lnk_q.data_cnt != 5'd0) begin
            // First address bit after a data phase starts a new frame
            lnk_d.addr_cnt = 4'd1;
         end else if (lnk_q.addr_cnt != 4'(RIF_ADDR_BITS)) begin
            lnk_d.addr_cnt = lnk_q.addr_cnt + 4'd1;
         end
      end else begin
         // Data phase, address count kept for the frame check
         if (lnk_q.data_cnt != 5'(RIF_DATA_BITS)) begin
            lnk_d.data_sh  = {ctl_data_i, lnk_q.data_sh[15:1]};
            lnk_d.data_cnt = lnk_q.data_cnt + 5'd1;
         end
      end
   end

   // Link register, only clocks during frames
   always_ff @(posedge ctl_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lnk_q <= '0;
      end else begin
         lnk_q <= lnk_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System domain
   ////////////////////////////////////////////////////////////////////////////

   rif_sys_t sys_q;                               // System state
   rif_sys_t sys_d;                               // System next state

   logic        frame_end;                        // Enable seen falling
   logic        word_ok;                          // Frame is complete and addressed
   logic [3:0]  cmd;                              // Command address of the frame
   logic        nonpcm_sel;                       // Chosen non-PCM condition
   logic        fs_evt;                           // fs change that counts
   logic        cs_same;                          // Status bits unchanged
   logic        pc_same;                          // Pc value unchanged
   logic        fault_raw;                        // Fault before forcing
   logic [7:0]  events;                           // Raw interrupt events
   logic [5:0]  rel_target;                       // Release count
   logic [11:0] wait_cyc;                         // Switch wait cycles

   // Register fields and decode, link word is stable while enable is low
   always_comb begin
      frame_end = sys_q.ce_sync[2] && !sys_q.ce_sync[1];
      cmd       = lnk_q.data_sh[RIF_POS_CMD +: 4];
      word_ok   = frame_end
                  && (lnk_q.addr_sh == RIF_CHIP_ADDR)
                  && (lnk_q.addr_cnt == 4'(RIF_ADDR_BITS))
                  && (lnk_q.data_cnt == 5'(RIF_DATA_BITS))
                  && (lnk_q.data_sh[RIF_POS_ADDR_HI] == sys_q.ahi_sync[1])
                  && (lnk_q.data_sh[RIF_POS_CAL] == sys_q.cal_sync[1]);
   end

   // Selects for wait time and release count
   always_comb begin
      unique case (sys_q.err_cfg[RIF_EC_WAIT +: 2])
         2'b00: wait_cyc = RIF_WAIT0_CYC;
         2'b01: wait_cyc = RIF_WAIT1_CYC;
         2'b10: wait_cyc = RIF_WAIT2_CYC;
         2'b11: wait_cyc = RIF_WAIT3_CYC;
      endcase
      unique case (sys_q.err_cfg[RIF_EC_RELEASE +: 2])
         2'b00: rel_target = RIF_REL0_CNT;
         2'b01: rel_target = RIF_REL1_CNT;
         2'b10: rel_target = RIF_REL2_CNT;
         2'b11: rel_target = RIF_REL3_CNT;
      endcase
   end

   // Next state of the system side
   always_comb begin
      sys_d = sys_q;

      // Synchronisers for enable and chip address straps
      sys_d.ce_sync  = {sys_q.ce_sync[1:0], ctl_enable_i};
      sys_d.ahi_sync = {sys_q.ahi_sync[0], chip_addr_high_i};
      sys_d.cal_sync = {sys_q.cal_sync[0], chip_addr_low_i};

      // Register writes
      if (word_ok && cmd == RIF_CMD_INT_EN) begin
         sys_d.int_en = lnk_q.data_sh[RIF_POS_BYTE +: 8];
      end
      if (word_ok && cmd == RIF_CMD_ERR_CFG) begin
         sys_d.err_cfg = lnk_q.data_sh[RIF_POS_BYTE +: 8];
      end

      // Non-PCM condition from the indicator source select
      nonpcm_sel = nonpcm_indicator_source_select_i ? nonpcm_b_i : nonpcm_a_i;
      sys_d.nonpcm = nonpcm_sel;

      // Status and Pc comparison against the previous block
      cs_same = cs_block_i && (cs_bits_i == sys_q.cs_prev);
      pc_same = pc_valid_i && (pc_value_i == sys_q.pc_prev);
      if (cs_block_i) begin
         sys_d.cs_prev = cs_bits_i;
      end
      if (pc_valid_i) begin
         sys_d.pc_prev = pc_value_i;
      end

      // fs change source, calculation ignored when the fs bit is set
      if (sys_q.err_cfg[RIF_EC_FS_UPDATE_ENABLE]) begin
         fs_evt = cs_fs_change_i;
      end else begin
         fs_evt = cs_fs_change_i || calc_fs_change_i;
      end
      sys_d.fs_chg = fs_evt;

      // Release after lock, counted in preamble B
      sys_d.lock_prev = pll_lock_i;
      if (!pll_lock_i) begin
         sys_d.released = 1'b0;
         sys_d.rel_cnt  = 6'd0;
      end else if (!sys_q.lock_prev) begin
         sys_d.rel_cnt  = 6'd0;
      end else if (!sys_q.released && preamble_b_i) begin
         if (sys_q.rel_cnt + 6'd1 >= rel_target) begin
            sys_d.released = 1'b1;
         end
         sys_d.rel_cnt = sys_q.rel_cnt + 6'd1;
      end

      // Clock switch sequencer
      unique case (sys_q.sw_state)
         RIF_SW_IDLE: begin
            if (sys_q.lock_prev && !pll_lock_i) begin
               sys_d.sw_state  = RIF_SW_AMP;
               sys_d.switching = 1'b1;
            end
         end
         RIF_SW_AMP: begin
            // Wait for the amplifier, or abandon on relock
            if (pll_lock_i) begin
               sys_d.sw_state  = RIF_SW_IDLE;
               sys_d.switching = 1'b0;
            end else if (osc_amp_start_i || osc_amp_operation_i) begin
               sys_d.sw_cnt   = wait_cyc;
               sys_d.sw_state = RIF_SW_COUNT;
            end
         end
         RIF_SW_COUNT: begin
            if (sys_q.sw_cnt <= 12'd1) begin
               sys_d.clk_osc   = 1'b1;
               sys_d.switching = 1'b0;
               sys_d.sw_state  = RIF_SW_IDLE;
            end else begin
               sys_d.sw_cnt = sys_q.sw_cnt - 12'd1;
            end
         end
      endcase
      if (pll_lock_i && sys_q.released) begin
         sys_d.clk_osc = 1'b0;
      end

      // Fault composition
      fault_raw = !sys_q.released || data_error_i || !pll_lock_i;
      if (sys_q.err_cfg[RIF_EC_CONTENT] && nonpcm_sel) begin
         fault_raw = 1'b1;
      end
      if (!sys_q.err_cfg[RIF_EC_FS_UPDATE_ENABLE] && fs_evt) begin
         fault_raw = 1'b1;
      end
      if (sys_q.switching && !osc_amp_operation_i && !sys_q.err_cfg[RIF_EC_FS_UPDATE_ENABLE]) begin
         fault_raw = 1'b1;
      end
      sys_d.fault = fault_raw || sys_q.err_cfg[RIF_EC_FORCE];

      // Mute depends on content, never on the force bit
      sys_d.mute = sys_q.err_cfg[RIF_EC_CONTENT] && nonpcm_sel;

      // Parity flag window
      if (sys_q.err_cfg[RIF_EC_PARITY]) begin
         sys_d.parity = parity_burst_i && subframe_err_i;
      end else begin
         sys_d.parity = parity_burst_i && nonpcm_sel;
      end

      // Interrupt events
      events = '0;
      events[RIF_IE_FAULT]  = sys_d.fault != sys_q.fault;
      events[RIF_IE_DETECT] = input_detect_i != sys_q.det_prev;
      events[RIF_IE_FS]     = fs_update_i;
      events[RIF_IE_CHSTAT] = cs_same;
      events[RIF_IE_NONPCM] = nonpcm_sel != sys_q.npcm_prev;
      events[RIF_IE_PC]     = pc_same;
      events[RIF_IE_SLIP]   = slip_i && slave_mode_i;
      events[RIF_IE_EMPH]   = emphasis_i;
      sys_d.det_prev  = input_detect_i;
      sys_d.npcm_prev = nonpcm_sel;
      sys_d.int_q     = |(events & sys_q.int_en);
   end

   // System register
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sys_q          <= '0;
         sys_q.int_en   <= RIF_INT_EN_RST;
         sys_q.err_cfg  <= RIF_ERR_CFG_RST;
         sys_q.fault    <= 1'b1;
         sys_q.sw_state <= RIF_SW_IDLE;
      end else begin
         sys_q <= sys_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   ////////////////////////////////////////////////////////////////////////////

   // All outputs come straight from state flops
   always_comb begin
      int_o               = sys_q.int_q;
      receive_fault_pin_o = sys_q.fault;
      mute_o              = sys_q.mute;
      parity_flag_o       = sys_q.parity;
      fs_change_o         = sys_q.fs_chg;
      clk_src_osc_o       = sys_q.clk_osc;
      nonpcm_o            = sys_q.nonpcm;
   end

endmodule : rif_top

// ### rif_host_model.sv
// Host model that writes the command registers over the serial control port
`timescale 1ns/1ns

module rif_host_model (
   output logic ctl_clk_o,     // Link clock, still between frames
   output logic ctl_enable_o,  // Low for address, high for data
   output logic ctl_data_o     // Serial data, LSB first
);

   // Idle lines at time zero
   initial begin
      ctl_clk_o    = 1'b0;
      ctl_enable_o = 1'b0;
      ctl_data_o   = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data moves while the clock is low; the device samples on the rise
   task automatic bit_out(input logic b);
      ctl_data_o = b;
      #3 ctl_clk_o = 1'b1;
      #3 ctl_clk_o = 1'b0;
   endtask : bit_out

   // One frame: address byte, then a 16-bit word with straps at zero
   task automatic send(input logic [7:0] a, input logic [3:0] c, input logic [7:0] d);
      logic [15:0] w;
      w = {d, c, 4'h0};
      for (int i = 0; i < 8; i++) bit_out(a[i]);
      ctl_enable_o = 1'b1;
      for (int i = 0; i < 16; i++) bit_out(w[i]);
      #3 ctl_enable_o = 1'b0;
      // Released line must not look like a held bit
      ctl_data_o = ~w[15];
      // Keeps the gap between frames well over the minimum
      #1000;
   endtask : send

endmodule : rif_host_model

// ### rif_checker.sv
// Checker for the fault, mute, parity and non-PCM outputs
`timescale 1ns/1ns

module rif_checker (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic pll_lock_i,
   input wire logic data_error_i,
   input wire logic cs_fs_change_i,
   input wire logic nonpcm_a_i,
   input wire logic nonpcm_b_i,
   input wire logic nonpcm_indicator_source_select_i,
   input wire logic parity_burst_i,
   input wire logic receive_fault_pin_o,
   input wire logic mute_o,
   input wire logic parity_flag_o,
   input wire logic fs_change_o,
   input wire logic nonpcm_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // Non-PCM level picked by the source select
   wire np_pick = nonpcm_indicator_source_select_i ? nonpcm_b_i : nonpcm_a_i;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_relock; $rose(pll_lock_i); endsequence
   sequence s_held; receive_fault_pin_o [*2]; endsequence

   property p_lock_fault; !pll_lock_i |=> receive_fault_pin_o; endproperty
   a_lock_fault: assert property (p_lock_fault) else $error("fault low while unlocked");
   property p_derr; data_error_i |=> receive_fault_pin_o; endproperty
   a_derr: assert property (p_derr) else $error("fault low on data error");
   property p_relock; s_relock |=> s_held; endproperty
   a_relock: assert property (p_relock) else $error("fault released too soon");
   property p_fell;
      $fell(receive_fault_pin_o) |-> $past(pll_lock_i) && !$past(data_error_i);
   endproperty
   a_fell: assert property (p_fell) else $error("fault released while in error");
   property p_npcm; 1'b1 |=> nonpcm_o == $past(np_pick); endproperty
   a_npcm: assert property (p_npcm) else $error("nonpcm pin wrong source");
   property p_mute_np; mute_o |-> nonpcm_o; endproperty
   a_mute_np: assert property (p_mute_np) else $error("mute without nonpcm");
   property p_mute_fault; mute_o |-> receive_fault_pin_o; endproperty
   a_mute_fault: assert property (p_mute_fault) else $error("mute without fault");
   property p_fs_cs; cs_fs_change_i |=> fs_change_o; endproperty
   a_fs_cs: assert property (p_fs_cs) else $error("status fs change missed");
   property p_parity; parity_flag_o |-> $past(parity_burst_i); endproperty
   a_parity: assert property (p_parity) else $error("parity flag without burst");

endmodule : rif_checker

bind rif_top rif_checker rif_checker_inst (.clk_sys_i, .rst_n_i, .pll_lock_i,
   .data_error_i, .cs_fs_change_i, .nonpcm_a_i, .nonpcm_b_i,
   .nonpcm_indicator_source_select_i, .parity_burst_i, .receive_fault_pin_o, .mute_o,
   .parity_flag_o, .fs_change_o, .nonpcm_o);

// ### tb_rif_top.sv
// Testbench for the interrupt and receive fault pin block
`timescale 1ns/1ns

module tb_rif_top;
   import rif_pkg::*;

   logic clk_sys_i = 0, rst_n_i = 0, ctl_clk_i, ctl_enable_i, ctl_data_i;
   logic pll_lock_i = 0, data_error_i = 0, input_detect_i = 0, fs_update_i = 0;
   logic calc_fs_change_i = 0, cs_fs_change_i = 0, cs_block_i = 0, pc_valid_i = 0;
   logic [47:0] cs_bits_i = '0;
   logic [15:0] pc_value_i = '0;
   logic nonpcm_a_i = 0, nonpcm_b_i = 0, nonpcm_indicator_source_select_i = 0;
   logic slip_i = 0, slave_mode_i = 0, emphasis_i = 0, parity_burst_i = 0;
   logic subframe_err_i = 0, preamble_b_i = 0, osc_amp_start_i = 0;
   logic int_o, receive_fault_pin_o, mute_o, parity_flag_o, fs_change_o;
   logic clk_src_osc_o, nonpcm_o;
   int err_total = 0;
   int cmp_count = 0;

   always #50 clk_sys_i = ~clk_sys_i;

   rif_host_model rif_host_model_inst (.ctl_clk_o(ctl_clk_i), .ctl_enable_o(ctl_enable_i),
      .ctl_data_o(ctl_data_i));
   rif_top rif_top_inst (.clk_sys_i, .rst_n_i, .ctl_clk_i, .ctl_enable_i, .ctl_data_i,
      .chip_addr_high_i(1'b0), .chip_addr_low_i(1'b0), .pll_lock_i, .data_error_i,
      .input_detect_i, .fs_update_i, .calc_fs_change_i, .cs_fs_change_i, .cs_block_i,
      .cs_bits_i, .pc_valid_i, .pc_value_i, .nonpcm_a_i, .nonpcm_b_i,
      .nonpcm_indicator_source_select_i, .slip_i, .slave_mode_i, .emphasis_i,
      .parity_burst_i, .subframe_err_i, .preamble_b_i, .osc_amp_start_i,
      .osc_amp_operation_i(1'b0), .int_o, .receive_fault_pin_o, .mute_o, .parity_flag_o,
      .fs_change_o, .clk_src_osc_o, .nonpcm_o);

   ////////////////////////////////////////////////////////////////////////////
   // Compare one output bit and count it
   task automatic chk(input logic g, input logic e, input string m);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : cyc
   // One-cycle pulse that returns while the registered answer stands
   task automatic pulse1(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask : pulse1
   task automatic pulse(ref logic s);
      pulse1(s);
      cyc(1);
   endtask : pulse
   // Register write, then room for the crossing into the system clock
   task automatic wr(input logic [3:0] c, input logic [7:0] d);
      rif_host_model_inst.send(RIF_CHIP_ADDR, c, d);
      cyc(6);
   endtask : wr
   // Was int_o (w=0) or the fault pin seen high over five cycles
   task automatic seen(input int w, input logic e, input string m);
      logic s;
      s = 1'b0;
      repeat (5) begin
         s |= (w == 0) ? int_o : receive_fault_pin_o;
         cyc(1);
      end
      chk(s, e, m);
   endtask : seen
   task automatic fire(input int b);
      case (b)
         0: data_error_i = ~data_error_i;
         1: input_detect_i = ~input_detect_i;
         2: pulse1(fs_update_i);
         3: pulse1(cs_block_i);
         4: nonpcm_a_i = ~nonpcm_a_i;
         5: pulse1(pc_valid_i);
         6: pulse1(slip_i);
         default: emphasis_i = 1'b1;
      endcase
   endtask : fire

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_release;
      int cnt[4] = '{48, 24, 12, 6};
      // Shortest delay first, ending on the longest one
      for (int k = 3; k >= 0; k--) begin
         pll_lock_i = 1'b0;
         cyc(2);
         chk(receive_fault_pin_o, 1'b1, "fault while unlocked");
         wr(RIF_CMD_ERR_CFG, 8'(k << 6));
         pll_lock_i = 1'b1;
         cyc(1);
         repeat (cnt[k] - 1) pulse(preamble_b_i);
         chk(receive_fault_pin_o, 1'b1, "fault before count");
         pulse(preamble_b_i);
         cyc(1);
         chk(receive_fault_pin_o, 1'b0, "fault after count");
      end
   endtask : t_release

   task automatic t_int;
      slave_mode_i = 1'b1;
      for (int b = 0; b < 8; b++) begin
         wr(RIF_CMD_INT_EN, 8'h00);
         fire(b);
         seen(0, 1'b0, "int from disabled source");
         emphasis_i = 1'b0;
         cyc(2);
         wr(RIF_CMD_INT_EN, 8'(1 << b));
         fire(b);
         seen(0, 1'b1, "int from enabled source");
         emphasis_i = 1'b0;
         cyc(2);
      end
      wr(RIF_CMD_INT_EN, 8'h28);
      cs_bits_i = 48'h1;
      pc_value_i = 16'h1;
      pulse1(cs_block_i);
      seen(0, 1'b0, "status differs");
      pulse1(pc_valid_i);
      seen(0, 1'b0, "pc differs");
      pulse1(cs_block_i);
      seen(0, 1'b1, "status same");
      pulse1(pc_valid_i);
      seen(0, 1'b1, "pc same");
   endtask : t_int

   task automatic t_fault;
      rif_host_model_inst.send(8'he9, RIF_CMD_ERR_CFG, 8'h10);
      cyc(6);
      chk(receive_fault_pin_o, 1'b0, "wrong address taken");
      wr(RIF_CMD_ERR_CFG, 8'h10);
      chk(receive_fault_pin_o, 1'b1, "forced fault");
      chk(mute_o, 1'b0, "force muted audio");
      wr(RIF_CMD_ERR_CFG, 8'h00);
      nonpcm_a_i = 1'b1;
      cyc(2);
      chk(receive_fault_pin_o, 1'b0, "nonpcm in fault");
      wr(RIF_CMD_ERR_CFG, 8'h01);
      chk(receive_fault_pin_o, 1'b1, "nonpcm not in fault");
      chk(mute_o, 1'b1, "nonpcm fault not muted");
      nonpcm_indicator_source_select_i = 1'b1;
      cyc(2);
      chk(nonpcm_o, 1'b0, "nonpcm source");
      chk(receive_fault_pin_o, 1'b0, "fault nonpcm source");
      nonpcm_b_i = 1'b1;
      parity_burst_i = 1'b1;
      cyc(2);
      chk(parity_flag_o, 1'b1, "parity during nonpcm");
      wr(RIF_CMD_ERR_CFG, 8'h02);
      chk(parity_flag_o, 1'b0, "parity outside subframe");
      subframe_err_i = 1'b1;
      cyc(2);
      chk(parity_flag_o, 1'b1, "parity in subframe");
      {subframe_err_i, parity_burst_i, nonpcm_b_i, nonpcm_a_i} = 4'h0;
      nonpcm_indicator_source_select_i = 1'b0;
      wr(RIF_CMD_ERR_CFG, 8'h00);
      calc_fs_change_i = 1'b1;
      cyc(1);
      chk(fs_change_o, 1'b1, "calc fs not seen");
      calc_fs_change_i = 1'b0;
      seen(1, 1'b1, "fs change not in fault");
      wr(RIF_CMD_ERR_CFG, 8'h20);
      calc_fs_change_i = 1'b1;
      cyc(1);
      chk(fs_change_o, 1'b0, "calc fs seen");
      calc_fs_change_i = 1'b0;
      seen(1, 1'b0, "calc fs in fault");
      cs_fs_change_i = 1'b1;
      cyc(1);
      chk(fs_change_o, 1'b1, "status fs not seen");
      cs_fs_change_i = 1'b0;
      seen(1, 1'b0, "status fs in fault");
   endtask : t_fault

   task automatic t_switch;
      int n[4] = '{2000, 1000, 500, 4000};
      for (int k = 0; k < 4; k++) begin
         wr(RIF_CMD_ERR_CFG, 8'(8'hc0 | (k << 2)));
         pll_lock_i = 1'b0;
         cyc(3);
         pulse(osc_amp_start_i);
         cyc(n[k] - 8);
         chk(clk_src_osc_o, 1'b0, "switch too early");
         cyc(12);
         chk(clk_src_osc_o, 1'b1, "switch missing");
         chk(receive_fault_pin_o, 1'b1, "no fault on switch");
         pll_lock_i = 1'b1;
         cyc(1);
         repeat (6) pulse(preamble_b_i);
         cyc(3);
         chk(clk_src_osc_o, 1'b0, "oscillator kept after lock");
      end
   endtask : t_switch

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      if (err_total == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   // Main sequence
   initial begin
      cyc(20);
      rst_n_i = 1'b1;
      cyc(4);
      chk(receive_fault_pin_o, 1'b1, "fault after reset");
      chk(int_o, 1'b0, "int after reset");
      t_release;
      t_int;
      t_fault;
      t_switch;
      wr(RIF_CMD_ERR_CFG, 8'h00);
      test_done;
   end

   // Watchdog, about six times the expected run
   initial begin
      #5000000;
      err_total++;
      test_done;
   end

endmodule : tb_rif_top
